// *** pkg/aes_pkg.sv ***
// Shared constants for the adaptive element shuffler
package aes_pkg;
  // Register port geometry
  localparam int          ADDR_W       = 12;             // Register address width
  localparam int          DATA_W       = 8;              // Register data width
  // Register offsets
  localparam logic [11:0] OFS_THR12    = 12'h342;        // Thresholds, rates one and two
  localparam logic [11:0] OFS_THR34    = 12'h343;        // Thresholds, rates three and four
  localparam logic [11:0] OFS_MRG_L    = 12'h107;        // Lower edge margin
  localparam logic [11:0] OFS_MRG_U    = 12'h108;        // Upper edge margin
  localparam logic [11:0] OFS_MRG_C    = 12'h109;        // Centre resonator offset
  // Reset values
  localparam logic [7:0]  RST_THR12    = 8'hf5;          // Every cycle, threshold 5
  localparam logic [7:0]  RST_THR34    = 8'hff;          // Both nibbles unused
  localparam logic [7:0]  RST_MRG_L    = 8'h05;          // Lower margin 5 MHz
  localparam logic [7:0]  RST_MRG_U    = 8'h05;          // Upper margin 5 MHz
  localparam logic [7:0]  RST_MRG_C    = 8'h00;          // Centre offset 0
  // Nibble fields
  localparam int          NIB_LO_LSB   = 0;              // Low nibble position
  localparam int          NIB_HI_LSB   = 4;              // High nibble position
  localparam logic [3:0]  NIB_UNUSED   = 4'hf;           // Never triggers
  localparam logic [3:0]  NIB_ALWAYS   = 4'h0;           // Always on
  // Quantizer and element geometry
  localparam int          QCODE_W      = 5;              // Signed code -8..+8
  localparam logic [3:0]  QCODE_MAX    = 4'h8;           // Peak magnitude
  localparam int          ELEM_N       = 16;             // Unit elements per DAC
  localparam int          ROT_W        = 4;              // Rotation index width
  // Timing counts
  localparam int          HOLD_CYCLES  = 64;             // Post-trigger hold, ADC cycles
  localparam int          HOLD_W       = 16;             // Hold counter width
  // Pseudorandom source
  localparam int          LFSR_W       = 16;             // Shift register width
  localparam logic [15:0] LFSR_TAPS    = 16'hb400;       // Maximal-length Galois taps
  localparam logic [15:0] LFSR_SEED    = 16'h0001;       // Non-zero start state
endpackage

// *** hw/aes_lfsr.sv ***
// Galois shift register feeding the element permutation
`timescale 1ns/1ps
`default_nettype none
module aes_lfsr #(
  parameter int          WIDTH = 16,
  parameter logic [15:0] TAPS  = 16'hb400,
  parameter logic [15:0] SEED  = 16'h0001
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Advance strobe
  input  wire logic             step,
  // Current state
  output logic [WIDTH-1:0]      state
);
  import aes_pkg::*;

  logic [WIDTH-1:0] state_reg;   // Shift register
  logic [WIDTH-1:0] state_next;  // Next shift value

  // Advance only on step; zero state can never be reached from seed
  always_comb begin
    state_next = state_reg;
    if (step) begin
      state_next = state_reg[0] ? ((state_reg >> 1) ^ TAPS[WIDTH-1:0]) : (state_reg >> 1);
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= SEED[WIDTH-1:0];
    end else begin
      state_reg <= state_next;
    end
  end

  assign state = state_reg;
endmodule
`default_nettype wire

// *** hw/aes_shuffler.sv ***
// Adaptive element shuffler: threshold trigger, hold, rate divider, element selection
`timescale 1ns/1ps
`default_nettype none
module aes_shuffler #(
  parameter int HOLD = aes_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // Register port
  input  wire logic [aes_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [aes_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [aes_pkg::DATA_W-1:0]    reg_rdata,
  output logic                               reg_rvalid,
  // Quantizer input
  input  wire logic signed [aes_pkg::QCODE_W-1:0] quant_code,
  // Feedback DAC side
  output logic      [aes_pkg::ELEM_N-1:0]    elem_enable,
  output logic                               shuffle_active,
  // Margin parameters toward resonator tuning
  output logic      [aes_pkg::DATA_W-1:0]    lower_edge_margin,
  output logic      [aes_pkg::DATA_W-1:0]    upper_edge_margin,
  output logic      [aes_pkg::DATA_W-1:0]    centre_resonator_offset
);
  import aes_pkg::*;

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD);  // Hold reload value

  // Configuration state
  logic [7:0] thr12_reg, thr12_next;    // Rates one and two
  logic [7:0] thr34_reg, thr34_next;    // Rates three and four
  logic [7:0] mrg_l_reg, mrg_l_next;    // Lower edge margin
  logic [7:0] mrg_u_reg, mrg_u_next;    // Upper edge margin
  logic [7:0] mrg_c_reg, mrg_c_next;    // Centre offset
  logic [7:0] rdata_reg, rdata_next;    // Read data
  logic       rvalid_reg, rvalid_next;  // Read answer strobe
  // Shuffling state
  logic [HOLD_W-1:0] hold_reg, hold_next;  // Post-trigger hold
  logic [1:0]        div_reg, div_next;    // Rate divider
  logic [ROT_W-1:0]  rot_reg, rot_next;    // Rotation of element pointer
  logic [ELEM_N-1:0] elem_reg, elem_next;  // Element enables
  logic              act_reg, act_next;    // Shuffler active
  // Decoded configuration
  logic              cfg_on;               // Some nibble in use
  logic [1:0]        rate_code;            // Interval minus one
  logic [3:0]        cur_thr;              // Active threshold
  logic [3:0]        peak;                 // Current code magnitude
  logic              trig;                 // Peak meets threshold
  logic              tick;                 // Reshuffle interval strobe
  logic [LFSR_W-1:0] lfsr_state;           // Pseudorandom source
  logic [4:0]        fill_cnt;             // Elements to switch on, code plus 8

  // Magnitude of a signed quantizer code, clamped to the peak
  function automatic logic [3:0] code_mag(input logic signed [QCODE_W-1:0] c);
    logic [QCODE_W-1:0] m;
    m = c[QCODE_W-1] ? QCODE_W'(-c) : QCODE_W'(c);
    return (m > QCODE_W'(QCODE_MAX)) ? QCODE_MAX : m[3:0];
  endfunction

  // First nibble not set to unused picks rate and threshold
  function automatic logic [6:0] pick_cfg(input logic [7:0] a, input logic [7:0] b);
    if (a[NIB_LO_LSB +: 4] != NIB_UNUSED) return {1'b1, 2'd0, a[NIB_LO_LSB +: 4]};
    if (a[NIB_HI_LSB +: 4] != NIB_UNUSED) return {1'b1, 2'd1, a[NIB_HI_LSB +: 4]};
    if (b[NIB_LO_LSB +: 4] != NIB_UNUSED) return {1'b1, 2'd2, b[NIB_LO_LSB +: 4]};
    if (b[NIB_HI_LSB +: 4] != NIB_UNUSED) return {1'b1, 2'd3, b[NIB_HI_LSB +: 4]};
    return {1'b0, 2'd0, NIB_UNUSED};
  endfunction

  // Register read decode; unmapped reads return zero
  function automatic logic [7:0] rd_mux(input logic [ADDR_W-1:0] a, input logic [7:0] t12,
                                        input logic [7:0] t34, input logic [7:0] ml,
                                        input logic [7:0] mu, input logic [7:0] mc);
    unique case (a)
      OFS_THR12: return t12;
      OFS_THR34: return t34;
      OFS_MRG_L: return ml;
      OFS_MRG_U: return mu;
      OFS_MRG_C: return mc;
      default:   return 8'h00;
    endcase
  endfunction

  // Register writes and registered read answer
  always_comb begin
    thr12_next  = thr12_reg;
    thr34_next  = thr34_reg;
    mrg_l_next  = mrg_l_reg;
    mrg_u_next  = mrg_u_reg;
    mrg_c_next  = mrg_c_reg;
    rvalid_next = reg_rd;
    rdata_next  = reg_rd ? rd_mux(reg_addr, thr12_reg, thr34_reg, mrg_l_reg, mrg_u_reg, mrg_c_reg) : rdata_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_THR12: thr12_next = reg_wdata;
        OFS_THR34: thr34_next = reg_wdata;
        OFS_MRG_L: mrg_l_next = reg_wdata;
        OFS_MRG_U: mrg_u_next = reg_wdata;
        OFS_MRG_C: mrg_c_next = reg_wdata;
        default:   ;  // Writes elsewhere dropped
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      thr12_reg  <= RST_THR12;
      thr34_reg  <= RST_THR34;
      mrg_l_reg  <= RST_MRG_L;
      mrg_u_reg  <= RST_MRG_U;
      mrg_c_reg  <= RST_MRG_C;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      thr12_reg  <= thr12_next;
      thr34_reg  <= thr34_next;
      mrg_l_reg  <= mrg_l_next;
      mrg_u_reg  <= mrg_u_next;
      mrg_c_reg  <= mrg_c_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Decode rate and threshold; priority favours the fastest rate if software misconfigures
  assign {cfg_on, rate_code, cur_thr} = pick_cfg(thr12_reg, thr34_reg);
  assign peak = code_mag(quant_code);
  // Zero is always on; anything above the peak can never be met
  assign trig = cfg_on && ((cur_thr == NIB_ALWAYS) || (peak >= cur_thr));
  assign tick = (div_reg == 2'd0);

  aes_lfsr #(
    .WIDTH (LFSR_W),
    .TAPS  (LFSR_TAPS),
    .SEED  (LFSR_SEED)
  ) u_lfsr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .step    (tick),
    .state   (lfsr_state)
  );

  // Hold, divider, rotation and element map
  always_comb begin
    div_next  = tick ? rate_code : 2'(div_reg - 2'd1);
    hold_next = hold_reg;
    if (!cfg_on) begin
      hold_next = '0;
    end else if (trig) begin
      hold_next = HOLD_LOAD;
    end else if (hold_reg != '0) begin
      hold_next = HOLD_W'(hold_reg - 1'b1);
    end
    act_next = cfg_on && (trig || (hold_reg != '0));
    // Pointer frozen at zero when idle so elements stay in fixed order
    if (!act_next) begin
      rot_next = '0;
    end else if (tick) begin
      rot_next = lfsr_state[ROT_W-1:0];
    end else begin
      rot_next = rot_reg;
    end
    // Thermometer of code+8 starting at the rotated pointer
    // Unsigned sum on purpose: a signed 5-bit +16 would wrap negative at full scale
    fill_cnt  = 5'($unsigned(quant_code) + 5'd8);
    elem_next = '0;
    for (int i = 0; i < ELEM_N; i++) begin
      if (5'(i) < fill_cnt) begin
        elem_next[ROT_W'(rot_next + ROT_W'(i))] = 1'b1;
      end
    end
  end

  // Shuffling state storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_reg <= '0;
      div_reg  <= 2'd0;
      rot_reg  <= '0;
      elem_reg <= '0;
      act_reg  <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      div_reg  <= div_next;
      rot_reg  <= rot_next;
      elem_reg <= elem_next;
      act_reg  <= act_next;
    end
  end

  assign reg_rdata               = rdata_reg;
  assign reg_rvalid              = rvalid_reg;
  assign elem_enable             = elem_reg;
  assign shuffle_active          = act_reg;
  assign lower_edge_margin       = mrg_l_reg;
  assign upper_edge_margin       = mrg_u_reg;
  assign centre_resonator_offset = mrg_c_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_idle3;
    !tick [*3];
  endsequence

  property p_reset_cfg;
    $past(rst) |-> thr12_reg == RST_THR12 && thr34_reg == RST_THR34 && mrg_l_reg == RST_MRG_L &&
                   mrg_u_reg == RST_MRG_U && mrg_c_reg == RST_MRG_C;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset configuration");

  property p_always_on;
    (cfg_on && cur_thr == 4'h0) |=> act_reg;
  endproperty
  a_always_on: assert property (p_always_on) else $error("zero threshold not active");

  property p_off;
    (thr12_reg == 8'hff && thr34_reg == 8'hff) |=> !act_reg && hold_reg == '0;
  endproperty
  a_off: assert property (p_off) else $error("shuffler not off");

  property p_trigger;
    (cfg_on && cur_thr != 4'h0 && peak >= cur_thr) |=> act_reg && hold_reg == HOLD_LOAD;
  endproperty
  a_trigger: assert property (p_trigger) else $error("peak did not trigger");

  property p_hold;
    (cfg_on && !trig && hold_reg != '0) |=> act_reg && hold_reg == $past(hold_reg) - 1'b1;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not counting");

  property p_rate4;
    (tick && rate_code == 2'd3) |=> s_idle3 ##1 tick;
  endproperty
  a_rate4: assert property (p_rate4) else $error("rate four spacing wrong");

  property p_rate2;
    (tick && rate_code == 2'd1) |=> !tick ##1 tick;
  endproperty
  a_rate2: assert property (p_rate2) else $error("rate two spacing wrong");

  property p_lfsr;
    tick |=> lfsr_state != $past(lfsr_state);
  endproperty
  a_lfsr: assert property (p_lfsr) else $error("shift register did not step");

  property p_elem_count;
    1'b1 |=> $countones(elem_reg) == int'($past(quant_code)) + 8 && (act_reg || rot_reg == '0);
  endproperty
  a_elem_count: assert property (p_elem_count) else $error("element count wrong");

  property p_read;
    (reg_rd && reg_addr == OFS_THR34) |=> reg_rvalid && reg_rdata == $past(thr34_reg);
  endproperty
  a_read: assert property (p_read) else $error("threshold readback wrong");
endmodule
`default_nettype wire

// *** bench/aes_quant_dac_model.sv ***
// Quantizer and feedback DAC stand-in facing the shuffler
`timescale 1ns/1ps
`default_nettype none
module aes_quant_dac_model (
  // Quantizer side
  input  wire logic signed [aes_pkg::QCODE_W-1:0] code_req,
  output logic signed      [aes_pkg::QCODE_W-1:0] quant_code,
  // DAC side
  input  wire logic        [aes_pkg::ELEM_N-1:0]  elem_enable,
  output logic             [15:0]                 elem_ones
);
  import aes_pkg::*;
  // Quantizer holds its code for the whole cycle
  assign quant_code = code_req;
  // Elements summed by the DAC; an unknown bit spoils the sum on purpose
  always_comb begin
    elem_ones = 16'h0000;
    for (int i = 0; i < ELEM_N; i++) begin
      elem_ones = elem_ones + 16'(elem_enable[i]);
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the adaptive element shuffler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aes_pkg::*;
  localparam int         HOLD_T = 4;       // Short hold keeps the run brief
  localparam logic [15:0] ON    = 16'h0001; // Active level
  localparam logic [15:0] OFF   = 16'h0000; // Idle level
  // Design connections
  logic                      sys_clk;
  logic                      rst;
  logic [ADDR_W-1:0]         reg_addr;
  logic [DATA_W-1:0]         reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [DATA_W-1:0]         reg_rdata;
  logic                      reg_rvalid;
  logic signed [QCODE_W-1:0] code_req;
  logic signed [QCODE_W-1:0] quant_code;
  logic [ELEM_N-1:0]         elem_enable;
  logic                      shuffle_active;
  logic [DATA_W-1:0]         lm;
  logic [DATA_W-1:0]         um;
  logic [DATA_W-1:0]         cm;
  logic [15:0]               elem_ones;
  logic [15:0]               prev_elem;
  // Bookkeeping
  int                        errors = 0;
  int                        total_checks = 0;
  int                        cycles = 0;
  int                        chg;

  aes_shuffler #(.HOLD(HOLD_T)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .quant_code(quant_code), .elem_enable(elem_enable), .shuffle_active(shuffle_active),
    .lower_edge_margin(lm), .upper_edge_margin(um), .centre_resonator_offset(cm)
  );
  aes_quant_dac_model i_model (
    .code_req(code_req), .quant_code(quant_code), .elem_enable(elem_enable), .elem_ones(elem_ones)
  );

  // Free-running 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Compare one value against its expectation
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One cycle with a given quantizer code, outputs settled afterwards
  task automatic tick(input logic signed [4:0] c);
    code_req = c;
    @(posedge sys_clk);
    #1;
  endtask

  // Register write; extra edge so strobes never toggle twice in a step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // Register read; answer is checked in its single valid cycle
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    chk({7'h00, reg_rvalid, reg_rdata}, {8'h01, exp});
    @(posedge sys_clk);
    #1;
  endtask

  // Program one rate nibble, all others left unused
  task automatic set_rate(input int k, input logic [3:0] n);
    logic [15:0] v;
    v = 16'hffff;
    v[4*(k-1) +: 4] = n;
    wr(OFS_THR12, v[7:0]);
    wr(OFS_THR34, v[15:8]);
  endtask

  // Active must last exactly the hold length after the last trigger
  task automatic hold_check;
    repeat (HOLD_T) begin
      tick(5'sh00);
      chk(16'(shuffle_active), ON);
    end
    tick(5'sh00);
    chk(16'(shuffle_active), OFF);
  endtask

  // Cycle budget guards against a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      wrap_up;
    end
  end

  initial begin
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    code_req = 5'sh00;
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    // Reset contents and unmapped read
    rd(OFS_THR12, RST_THR12);
    rd(OFS_THR34, 8'hff);
    rd(OFS_MRG_L, 8'h05);
    rd(OFS_MRG_U, 8'h05);
    rd(OFS_MRG_C, 8'h00);
    chk({lm, um}, 16'h0505);
    rd(12'h000, 8'h00);
    // Margins inside the recommended range
    wr(OFS_MRG_L, 8'h0a);
    wr(OFS_MRG_U, 8'h14);
    wr(OFS_MRG_C, 8'h02);
    rd(OFS_MRG_U, 8'h14);
    chk({lm, um}, 16'h0a14);
    chk(16'(cm), 16'h0002);
    // Default threshold: below stays idle, rotation parked at zero
    tick(5'sh04);
    chk(16'(shuffle_active), OFF);
    chk(elem_enable, 16'h0fff);
    tick(5'sh05);
    chk(16'(shuffle_active), ON);
    tick(5'sh00);
    tick(5'sh00);
    tick(-5'sh05);
    chk(16'(shuffle_active), ON);
    hold_check;
    // Each threshold from 3 to 8, negative peaks included
    for (int t = 3; t <= 8; t++) begin
      wr(OFS_THR12, {4'hf, 4'(t)});
      tick(5'(t - 1));
      chk(16'(shuffle_active), OFF);
      tick(-5'(t));
      chk(16'(shuffle_active), ON);
      chk(elem_ones, 16'(8 - t));
      repeat (HOLD_T + 2) tick(5'sh00);
    end
    // Every rate: always-on nibble, then a threshold of 5 in that nibble
    for (int k = 1; k <= 4; k++) begin
      set_rate(k, NIB_ALWAYS);
      repeat (8) tick(5'sh00);
      chk(16'(shuffle_active), ON);
      chg = 0;
      prev_elem = elem_enable;
      repeat (24) begin
        tick(5'sh00);
        if (elem_enable !== prev_elem) chg++;
        prev_elem = elem_enable;
        chk(elem_ones, 16'h0008);
      end
      chk(16'(chg > 0 && chg <= 24 / k), ON);
      set_rate(k, 4'h5);
      repeat (HOLD_T + 2) tick(5'sh00);
      tick(5'sh04);
      chk(16'(shuffle_active), OFF);
      tick(5'sh05);
      chk(16'(shuffle_active), ON);
      repeat (HOLD_T + 2) tick(5'sh00);
    end
    // All nibbles unused turns the shuffler off
    set_rate(1, NIB_UNUSED);
    tick(5'sh08);
    chk(16'(shuffle_active), OFF);
    chk(elem_enable, 16'hffff);
    tick(-5'sh08);
    chk(elem_enable, 16'h0000);
    rd(OFS_THR34, 8'hff);
    wrap_up;
  end
endmodule
`default_nettype wire
